// ==== rtl/ppc_port_pin_control.sv ====
// Port pin control: directions, pin data, resource routing, pin overrides.
//
// Behaviour
// - Selector 101 low-priority rising, 110 high-priority falling, 111 low falling; OR.
// - Selector 100 gives high-priority interrupt on rising edge; 000 connects nothing.
// - Selectors 010 and 011 route pin to timer 0 and timer 1 gates.
// - Direction bits: low reg pins 7..1, mid reg pins 15..8, bit 1 pin 17.
// - Direction is ignored while a pin serves a non-port function such as LCD.
// - Data reads return live pin levels; LCD pins read zero.
// - Data writes only affect output pins; input and LCD pins ignore them.
// - Data map: low 7..1 plus push-button bit 0, mid 15..8, 17, 28-29.
// - Memory mode 00 off, 01 two-wire, 10 three-wire; pins 4 clock, 5 data.
`timescale 1ns/1ps
`default_nettype none
module ppc_port_pin_control (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic [7:0]  i_sfr_wdata,
  output var  logic [7:0]  o_sfr_rdata,
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [15:0] i_cfg_addr,
  input  wire logic [7:0]  i_cfg_wdata,
  output var  logic [7:0]  o_cfg_rdata,
  input  wire logic [29:0] i_pin_in,
  input  wire logic [29:0] i_pin_lcd,
  output var  logic [29:0] o_pin_out,
  output var  logic [29:0] o_pin_oe_b,
  input  wire logic        i_push_button_input,
  input  wire logic        i_receive_pin,
  input  wire logic        i_eeprom_serial_clock,
  input  wire logic        i_eeprom_data_out,
  input  wire logic        i_eeprom_data_drive,
  output var  logic        o_eeprom_data_in,
  input  wire logic        i_reactive_energy_pulse,
  input  wire logic        i_active_energy_pulse,
  input  wire logic        i_aux1_pulse,
  input  wire logic        i_aux2_pulse,
  output var  logic        o_high_priority_interrupt,
  output var  logic        o_low_priority_interrupt,
  output var  logic        o_timer0_clock_gate,
  output var  logic        o_timer1_clock_gate,
  output var  logic [7:0]  o_eeprom_serial_data,
  output var  logic [7:0]  o_eeprom_serial_control,
  output var  logic [1:0]  o_eeprom_pin_mode
);
  logic [29:0] pin_s1_ff, pin_s2_ff, dir_ff, data_ff, nxt_out, nxt_oe_b;
  logic [29:0] wr_vec, wr_mask, pin_vis;
  logic [1:0]  misc_s1_ff, misc_s2_ff, res_prev_ff, res_src;
  logic        pv_ff, pw_ff, px_ff, py_ff, ee_on;
  logic        nxt_hi, nxt_lo, nxt_t0, nxt_t1;
  logic [2:0]  pin11_sel_ff, rx_sel_ff;
  logic [7:0]  nxt_sfr, nxt_cfg;

  // Pins arrive from outside, so every level passes two flip-flops first.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_s1_ff  <= ppc_pkg::RST_PINS;
      pin_s2_ff  <= ppc_pkg::RST_PINS;
      misc_s1_ff <= 2'h0;
      misc_s2_ff <= 2'h0;
      res_prev_ff <= 2'h0;
    end else begin
      pin_s1_ff  <= i_pin_in;
      pin_s2_ff  <= pin_s1_ff;
      misc_s1_ff <= {i_push_button_input, i_receive_pin};
      misc_s2_ff <= misc_s1_ff;
      res_prev_ff <= res_src;
    end
  end

  assign res_src = {misc_s2_ff[0], pin_s2_ff[ppc_pkg::PIN_RES]};
  assign pin_vis = pin_s2_ff & ~i_pin_lcd;
  assign ee_on   = (o_eeprom_pin_mode == ppc_pkg::EE_TWO) ||
                   (o_eeprom_pin_mode == ppc_pkg::EE_THREE);

  // Several sources routed to one resource are ORed together.
  always_comb begin
    logic [2:0] sel;
    logic       rise;
    logic       fall;
    sel = ppc_pkg::RES_NONE;
    rise = 1'b0;
    fall = 1'b0;
    nxt_hi = 1'b0;
    nxt_lo = 1'b0;
    nxt_t0 = 1'b0;
    nxt_t1 = 1'b0;
    for (int i = 0; i < 2; i++) begin
      sel  = (i == 0) ? pin11_sel_ff : rx_sel_ff;
      rise = res_src[i] & ~res_prev_ff[i];
      fall = ~res_src[i] & res_prev_ff[i];
      case (sel)
        ppc_pkg::RES_TIMER0:  nxt_t0 = nxt_t0 | res_src[i];
        ppc_pkg::RES_TIMER1:  nxt_t1 = nxt_t1 | res_src[i];
        ppc_pkg::RES_HI_RISE: nxt_hi = nxt_hi | rise;
        ppc_pkg::RES_LO_RISE: nxt_lo = nxt_lo | rise;
        ppc_pkg::RES_HI_FALL: nxt_hi = nxt_hi | fall;
        ppc_pkg::RES_LO_FALL: nxt_lo = nxt_lo | fall;
        default:              nxt_hi = nxt_hi;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_high_priority_interrupt <= 1'b0;
      o_low_priority_interrupt  <= 1'b0;
      o_timer0_clock_gate       <= 1'b0;
      o_timer1_clock_gate       <= 1'b0;
    end else begin
      o_high_priority_interrupt <= nxt_hi;
      o_low_priority_interrupt  <= nxt_lo;
      o_timer0_clock_gate       <= nxt_t0;
      o_timer1_clock_gate       <= nxt_t1;
    end
  end

  // Decode of a pin-mapped data or direction write into a pin vector.
  always_comb begin
    wr_vec  = ppc_pkg::RST_PINS;
    wr_mask = ppc_pkg::RST_PINS;
    case (i_sfr_addr)
      ppc_pkg::SFR_DATA_LOW, ppc_pkg::SFR_DIR_LOW: begin
        wr_vec  = {22'h000000, i_sfr_wdata};
        wr_mask = ppc_pkg::MASK_LOW;
      end
      ppc_pkg::SFR_DATA_MID, ppc_pkg::SFR_DIR_MID: begin
        wr_vec  = {14'h0000, i_sfr_wdata, 8'h00};
        wr_mask = ppc_pkg::MASK_MID;
      end
      ppc_pkg::SFR_DATA_P17, ppc_pkg::SFR_DIR_P17: begin
        wr_vec  = {12'h000, i_sfr_wdata[1], 17'h00000};
        wr_mask = ppc_pkg::MASK_P17;
      end
      ppc_pkg::SFR_DATA_HIGH: begin
        wr_vec  = {i_sfr_wdata[5:4], 28'h0000000};
        wr_mask = ppc_pkg::MASK_HIGH;
      end
      default: wr_mask = ppc_pkg::RST_PINS;
    endcase
  end

  // Pins 28 and 29 have no direction register, so they stay inputs.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dir_ff <= ppc_pkg::RST_PINS;
    end else if (i_sfr_wr && (i_sfr_addr == ppc_pkg::SFR_DIR_LOW ||
                 i_sfr_addr == ppc_pkg::SFR_DIR_MID ||
                 i_sfr_addr == ppc_pkg::SFR_DIR_P17)) begin
      dir_ff <= (dir_ff & ~wr_mask) | (wr_vec & wr_mask);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      data_ff <= ppc_pkg::RST_PINS;
    end else if (i_sfr_wr && (i_sfr_addr == ppc_pkg::SFR_DATA_LOW ||
                 i_sfr_addr == ppc_pkg::SFR_DATA_MID ||
                 i_sfr_addr == ppc_pkg::SFR_DATA_P17 ||
                 i_sfr_addr == ppc_pkg::SFR_DATA_HIGH)) begin
      data_ff <= (data_ff & ~(wr_mask & dir_ff & ~i_pin_lcd)) |
                 (wr_vec & wr_mask & dir_ff & ~i_pin_lcd);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_eeprom_serial_data    <= ppc_pkg::RST_BYTE;
      o_eeprom_serial_control <= ppc_pkg::RST_BYTE;
    end else if (i_sfr_wr && i_sfr_addr == ppc_pkg::SFR_EE_DATA) begin
      o_eeprom_serial_data <= i_sfr_wdata;
    end else if (i_sfr_wr && i_sfr_addr == ppc_pkg::SFR_EE_CTRL) begin
      o_eeprom_serial_control <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_eeprom_pin_mode <= ppc_pkg::RST_MODE;
      pv_ff <= 1'b0;
      pw_ff <= 1'b0;
      px_ff <= 1'b0;
      py_ff <= 1'b0;
      pin11_sel_ff <= ppc_pkg::RST_SEL;
      rx_sel_ff    <= ppc_pkg::RST_SEL;
    end else if (i_cfg_wr) begin
      case (i_cfg_addr)
        ppc_pkg::CFG_PULSE_EE: begin
          o_eeprom_pin_mode <= i_cfg_wdata[ppc_pkg::EEX_LSB +: 2];
          pv_ff <= i_cfg_wdata[ppc_pkg::PV_BIT];
          pw_ff <= i_cfg_wdata[ppc_pkg::PW_BIT];
        end
        ppc_pkg::CFG_AUX: begin
          px_ff <= i_cfg_wdata[ppc_pkg::PX_BIT];
          py_ff <= i_cfg_wdata[ppc_pkg::PY_BIT];
        end
        ppc_pkg::CFG_PIN11: pin11_sel_ff <= i_cfg_wdata[ppc_pkg::R11_LSB +: 3];
        ppc_pkg::CFG_RX:    rx_sel_ff <= i_cfg_wdata[ppc_pkg::RRX_LSB +: 3];
        default:            pv_ff <= pv_ff;
      endcase
    end
  end

  // Special functions take the pin over; its direction bit then has no say.
  always_comb begin
    nxt_out  = data_ff;
    nxt_oe_b = ~(dir_ff & ~i_pin_lcd);
    if (ee_on) begin
      nxt_out[ppc_pkg::PIN_EE_CLK]   = i_eeprom_serial_clock;
      nxt_oe_b[ppc_pkg::PIN_EE_CLK]  = 1'b0;
      nxt_out[ppc_pkg::PIN_EE_DATA]  = i_eeprom_data_out;
      nxt_oe_b[ppc_pkg::PIN_EE_DATA] = ~i_eeprom_data_drive;
    end
    if (pw_ff) begin
      nxt_out[ppc_pkg::PIN_ACTIVE]  = i_active_energy_pulse;
      nxt_oe_b[ppc_pkg::PIN_ACTIVE] = 1'b0;
    end
    if (pv_ff) begin
      nxt_out[ppc_pkg::PIN_REACTIVE]  = i_reactive_energy_pulse;
      nxt_oe_b[ppc_pkg::PIN_REACTIVE] = 1'b0;
    end
    if (px_ff) begin
      nxt_out[ppc_pkg::PIN_AUX1]  = i_aux1_pulse;
      nxt_oe_b[ppc_pkg::PIN_AUX1] = 1'b0;
    end
    if (py_ff) begin
      nxt_out[ppc_pkg::PIN_AUX2]  = i_aux2_pulse;
      nxt_oe_b[ppc_pkg::PIN_AUX2] = 1'b0;
    end
  end

  always_comb begin
    case (i_sfr_addr)
      ppc_pkg::SFR_DATA_LOW:  nxt_sfr = {pin_vis[7:1], misc_s2_ff[1]};
      ppc_pkg::SFR_DATA_MID:  nxt_sfr = pin_vis[15:8];
      ppc_pkg::SFR_DATA_P17:  nxt_sfr = {6'h00, pin_vis[17], 1'b0};
      ppc_pkg::SFR_DATA_HIGH: nxt_sfr = {2'h0, pin_vis[29:28], 4'h0};
      ppc_pkg::SFR_DIR_LOW:   nxt_sfr = {dir_ff[7:1], 1'b0};
      ppc_pkg::SFR_DIR_MID:   nxt_sfr = dir_ff[15:8];
      ppc_pkg::SFR_DIR_P17:   nxt_sfr = {6'h00, dir_ff[17], 1'b0};
      ppc_pkg::SFR_EE_DATA:   nxt_sfr = o_eeprom_serial_data;
      ppc_pkg::SFR_EE_CTRL:   nxt_sfr = o_eeprom_serial_control;
      default:                nxt_sfr = 8'h00;
    endcase
    case (i_cfg_addr)
      ppc_pkg::CFG_PULSE_EE: nxt_cfg = {o_eeprom_pin_mode, 2'h0, pw_ff, pv_ff,
                                        2'h0};
      ppc_pkg::CFG_AUX:      nxt_cfg = {4'h0, px_ff, py_ff, 2'h0};
      ppc_pkg::CFG_PIN11:    nxt_cfg = {1'b0, pin11_sel_ff, 4'h0};
      ppc_pkg::CFG_RX:       nxt_cfg = {5'h00, rx_sel_ff};
      default:               nxt_cfg = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pin_out        <= ppc_pkg::RST_PINS;
      o_pin_oe_b       <= ppc_pkg::RST_OE_B;
      o_eeprom_data_in <= 1'b0;
      o_sfr_rdata      <= ppc_pkg::RST_BYTE;
      o_cfg_rdata      <= ppc_pkg::RST_BYTE;
    end else begin
      o_pin_out        <= nxt_out;
      o_pin_oe_b       <= nxt_oe_b;
      o_eeprom_data_in <= pin_s2_ff[ppc_pkg::PIN_EE_DATA];
      if (i_sfr_rd) o_sfr_rdata <= nxt_sfr;
      if (i_cfg_rd) o_cfg_rdata <= nxt_cfg;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_hi_rise_irq: assert property (
    pin11_sel_ff == ppc_pkg::RES_HI_RISE && $rose(pin_s2_ff[ppc_pkg::PIN_RES])
    |=> o_high_priority_interrupt) else $error("Rising edge lost.");
  a_lo_fall_irq: assert property (
    pin11_sel_ff == ppc_pkg::RES_LO_FALL && $fell(pin_s2_ff[ppc_pkg::PIN_RES])
    |=> o_low_priority_interrupt) else $error("Falling edge lost.");
  a_no_route_quiet: assert property (
    pin11_sel_ff == ppc_pkg::RES_NONE && rx_sel_ff == ppc_pkg::RES_NONE
    |=> !o_high_priority_interrupt && !o_low_priority_interrupt &&
        !o_timer0_clock_gate && !o_timer1_clock_gate)
    else $error("Unrouted pin raised a resource.");
  a_timer0_route: assert property (
    pin11_sel_ff == ppc_pkg::RES_TIMER0
    |=> o_timer0_clock_gate || !$past(pin_s2_ff[ppc_pkg::PIN_RES]))
    else $error("Timer gate does not follow pin.");
  a_dir_pin17_map: assert property (
    i_sfr_wr && i_sfr_addr == ppc_pkg::SFR_DIR_P17
    |=> dir_ff[17] == $past(i_sfr_wdata[1])) else $error("Pin 17 dir bad.");
  a_output_drive: assert property (
    dir_ff[12] && !i_pin_lcd[12]
    |=> !o_pin_oe_b[12] && o_pin_out[12] == $past(data_ff[12]))
    else $error("Output pin not driven.");
  a_lcd_no_drive: assert property (
    i_pin_lcd[13] |=> o_pin_oe_b[13]) else $error("LCD pin driven.");
  a_lcd_read_zero: assert property (
    i_sfr_rd && i_sfr_addr == ppc_pkg::SFR_DATA_MID && i_pin_lcd[15:8] == 8'hff
    |=> o_sfr_rdata == 8'h00) else $error("LCD pins read nonzero.");
  a_input_no_write: assert property (
    i_sfr_wr && i_sfr_addr == ppc_pkg::SFR_DATA_MID && dir_ff[15:8] == 8'h00
    |=> $stable(data_ff[15:8])) else $error("Input pin took a write.");
  a_button_read: assert property (
    i_sfr_rd && i_sfr_addr == ppc_pkg::SFR_DATA_LOW
    |=> o_sfr_rdata[0] == $past(misc_s2_ff[1])) else $error("Button bit bad.");
  a_eeprom_clock: assert property (
    ee_on |=> !o_pin_oe_b[ppc_pkg::PIN_EE_CLK] &&
    o_pin_out[ppc_pkg::PIN_EE_CLK] == $past(i_eeprom_serial_clock))
    else $error("Serial clock not on pin 4.");
  a_reactive_pin: assert property (
    pv_ff |=> !o_pin_oe_b[ppc_pkg::PIN_REACTIVE] &&
    o_pin_out[ppc_pkg::PIN_REACTIVE] == $past(i_reactive_energy_pulse))
    else $error("Reactive pulse not on pin 7.");
  a_aux1_pin: assert property (
    px_ff |=> !o_pin_oe_b[ppc_pkg::PIN_AUX1] &&
    o_pin_out[ppc_pkg::PIN_AUX1] == $past(i_aux1_pulse))
    else $error("Aux pulse not on pin 8.");
endmodule
`default_nettype wire

// ==== rtl/ppc_pkg.sv ====
// Package of register offsets, field positions and codes for the port pins.
package ppc_pkg;
  localparam int NPINS = 30;
  // Special-function register offsets.
  localparam logic [7:0] SFR_DATA_LOW  = 8'h80;
  localparam logic [7:0] SFR_DATA_MID  = 8'h90;
  localparam logic [7:0] SFR_DIR_MID   = 8'h91;
  localparam logic [7:0] SFR_EE_DATA   = 8'h9e;
  localparam logic [7:0] SFR_EE_CTRL   = 8'h9f;
  localparam logic [7:0] SFR_DATA_P17  = 8'ha0;
  localparam logic [7:0] SFR_DIR_P17   = 8'ha1;
  localparam logic [7:0] SFR_DIR_LOW   = 8'ha2;
  localparam logic [7:0] SFR_DATA_HIGH = 8'hb0;
  // Configuration register offsets.
  localparam logic [15:0] CFG_PULSE_EE = 16'h2008;
  localparam logic [15:0] CFG_PIN11    = 16'h200e;
  localparam logic [15:0] CFG_AUX      = 16'h200f;
  localparam logic [15:0] CFG_RX       = 16'h20af;
  // Field positions.
  localparam int EEX_LSB = 6;
  localparam int PW_BIT  = 3;
  localparam int PV_BIT  = 2;
  localparam int PX_BIT  = 3;
  localparam int PY_BIT  = 2;
  localparam int R11_LSB = 4;
  localparam int RRX_LSB = 0;
  // Pin numbers with a special role.
  localparam int PIN_EE_CLK   = 4;
  localparam int PIN_EE_DATA  = 5;
  localparam int PIN_ACTIVE   = 6;
  localparam int PIN_REACTIVE = 7;
  localparam int PIN_AUX1     = 8;
  localparam int PIN_AUX2     = 9;
  localparam int PIN_RES      = 11;
  // Implemented bits of each pin-mapped register, as pin masks.
  localparam logic [29:0] MASK_LOW  = 30'h000000fe;
  localparam logic [29:0] MASK_MID  = 30'h0000ff00;
  localparam logic [29:0] MASK_P17  = 30'h00020000;
  localparam logic [29:0] MASK_HIGH = 30'h30000000;
  // Resource selector codes.
  localparam logic [2:0] RES_NONE    = 3'h0;
  localparam logic [2:0] RES_TIMER0  = 3'h2;
  localparam logic [2:0] RES_TIMER1  = 3'h3;
  localparam logic [2:0] RES_HI_RISE = 3'h4;
  localparam logic [2:0] RES_LO_RISE = 3'h5;
  localparam logic [2:0] RES_HI_FALL = 3'h6;
  localparam logic [2:0] RES_LO_FALL = 3'h7;
  // Serial memory pin modes.
  localparam logic [1:0] EE_OFF   = 2'h0;
  localparam logic [1:0] EE_TWO   = 2'h1;
  localparam logic [1:0] EE_THREE = 2'h2;
  // Reset values.
  localparam logic [29:0] RST_PINS  = 30'h00000000;
  localparam logic [29:0] RST_OE_B  = 30'h3fffffff;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [2:0]  RST_SEL   = 3'h0;
  localparam logic [1:0]  RST_MODE  = 2'h0;
endpackage

// ==== testbench/ppc_pin_partner.sv ====
// Model of the board around the port pins: outside drivers and floating pins.
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_partner (
  input  wire logic        i_clk,
  input  wire logic [29:0] i_pin_out,
  input  wire logic [29:0] i_pin_oe_b,
  input  wire logic [29:0] i_ext_val,
  input  wire logic [29:0] i_ext_drv,
  output var  logic [29:0] o_pin_level
);
  logic [29:0] float_ff;
  // No pulls on these pins, so a floating pin keeps changing to expose reads.
  initial float_ff = 30'h15555555;
  always @(posedge i_clk) begin
    float_ff <= ~float_ff;
  end
  // The device wins where it drives; outside parts reach undriven pins only.
  assign o_pin_level = (~i_pin_oe_b & i_pin_out)
                     | (i_pin_oe_b & i_ext_drv & i_ext_val)
                     | (i_pin_oe_b & ~i_ext_drv & float_ff);
endmodule
`default_nettype wire

// ==== testbench/port_pin_control_tb_top.sv ====
// Self-checking bench for the port pin control block.
`timescale 1ns/1ps
`default_nettype none
module port_pin_control_tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        swr = 0, srd = 0, cwr = 0, crd = 0;
  logic [7:0]  sadr = 0, swd = 0, cwd = 0, srdat, crdat, rd, eed, eec;
  logic [15:0] cadr = 0;
  logic [29:0] lcd = 0, ext = 0, edrv = 30'h3fffffff, lvl, pout, oe_b;
  logic        btn = 0, rx = 0, eck = 0, edo = 0, edd = 0;
  logic        edi, ihi, ilo, tg0, tg1;
  logic [3:0]  pls = 0;
  logic [1:0]  emode;
  int          n_errors = 0, n_tests = 0, n_hi = 0, n_lo = 0;
  localparam logic [29:0] DRV = 30'h0002fffe;
  logic [7:0]  dadr [4] = '{8'h80, 8'h90, 8'ha0, 8'hb0};

  ppc_port_pin_control u_dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_sfr_wr(swr), .i_sfr_rd(srd),
    .i_sfr_addr(sadr), .i_sfr_wdata(swd), .o_sfr_rdata(srdat),
    .i_cfg_wr(cwr), .i_cfg_rd(crd), .i_cfg_addr(cadr),
    .i_cfg_wdata(cwd), .o_cfg_rdata(crdat), .i_pin_in(lvl),
    .i_pin_lcd(lcd), .o_pin_out(pout), .o_pin_oe_b(oe_b),
    .i_push_button_input(btn), .i_receive_pin(rx),
    .i_eeprom_serial_clock(eck), .i_eeprom_data_out(edo),
    .i_eeprom_data_drive(edd), .o_eeprom_data_in(edi),
    .i_reactive_energy_pulse(pls[1]), .i_active_energy_pulse(pls[0]),
    .i_aux1_pulse(pls[2]), .i_aux2_pulse(pls[3]),
    .o_high_priority_interrupt(ihi), .o_low_priority_interrupt(ilo),
    .o_timer0_clock_gate(tg0), .o_timer1_clock_gate(tg1),
    .o_eeprom_serial_data(eed), .o_eeprom_serial_control(eec),
    .o_eeprom_pin_mode(emode));

  ppc_pin_partner u_board (
    .i_clk(clk), .i_pin_out(pout), .i_pin_oe_b(oe_b), .i_ext_val(ext),
    .i_ext_drv(edrv), .o_pin_level(lvl));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (ihi === 1'b1) n_hi++;
    if (ilo === 1'b1) n_lo++;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] e,
                         input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pin(input string nm, input logic [29:0] e,
                         input logic [29:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Strobes last one edge; a read waits one more edge for registered data.
  task automatic bus(input logic c, input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    {cwr, crd, swr, srd} <= {c & w, c & !w, !c & w, !c & !w};
    cadr <= a;
    sadr <= a[7:0];
    {cwd, swd} <= {d, d};
    @(posedge clk);
    {cwr, crd, swr, srd} <= 4'h0;
    if (!w) begin
      @(posedge clk);
      #1 rd = c ? crdat : srdat;
    end
  endtask

  task automatic rd_chk(input logic c, input logic [15:0] a,
                        input logic [7:0] e, input string nm);
    bus(c, 1'b0, a, 8'h00);
    chk_reg(nm, e, rd);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Drives one pin edge and counts the interrupt pulses that follow.
  task automatic edge_chk(input logic on_rx, input logic v,
                          input logic [1:0] ex);
    settle(4);
    n_hi = 0;
    n_lo = 0;
    @(posedge clk);
    if (on_rx) rx <= v;
    else ext[11] <= v;
    settle(8);
    chk_reg("irq_count", {3'h0, ex[1], 3'h0, ex[0]}, {4'(n_hi), 4'(n_lo)});
  endtask

  function automatic logic [7:0] pbyte(logic [7:0] a, logic [29:0] p);
    case (a)
      8'h80:   return {p[7:1], 1'b0};
      8'h90:   return p[15:8];
      8'ha0:   return {6'h0, p[17], 1'b0};
      default: return {2'h0, p[29:28], 4'h0};
    endcase
  endfunction

  function automatic logic [1:0] exp_irq(logic [2:0] c, logic rise);
    if (rise)
      return {c == ppc_pkg::RES_HI_RISE, c == ppc_pkg::RES_LO_RISE};
    return {c == ppc_pkg::RES_HI_FALL, c == ppc_pkg::RES_LO_FALL};
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    logic [7:0]  dl, dm, en;
    logic [29:0] wd, dir, drv, lc, st, lv;
    void'($urandom(34185));
    st = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    settle(1);
    chk_pin("oe_b_reset", 30'h3fffffff, oe_b);
    rd_chk(0, 16'h00a2, 8'h00, "dir_low_reset");
    rd_chk(0, 16'h0091, 8'h00, "dir_mid_reset");
    rd_chk(1, ppc_pkg::CFG_PULSE_EE, 8'h00, "pulse_en_reset");
    rd_chk(1, ppc_pkg::CFG_AUX, 8'h00, "aux_en_reset");
    rd_chk(0, 16'h0081, 8'h00, "unmapped");
    for (int r = 0; r < 5; r++) begin
      dl = (r == 0) ? 8'hfe : 8'($urandom()) & 8'hfe;
      dm = (r == 0) ? 8'hff : 8'($urandom());
      dir = {12'h0, (r == 0) | 1'($urandom()), 1'b0, dm, dl};
      lc = (r > 2) ? 30'($urandom()) & DRV : '0;
      wd = 30'($urandom());
      drv = dir & ~lc;
      lcd <= lc;
      ext <= 30'($urandom());
      btn <= 1'($urandom());
      bus(0, 1, 16'h00a2, dl);
      bus(0, 1, 16'h0091, dm);
      bus(0, 1, 16'h00a1, {6'h0, dir[17], 1'b0});
      foreach (dadr[i]) bus(0, 1, {8'h00, dadr[i]}, pbyte(dadr[i], wd));
      st = (st & ~drv) | (wd & drv);
      settle(6);
      chk_pin("oe_b_dir", ~drv & DRV, oe_b & DRV);
      chk_pin("pin_out", st & drv, pout & drv);
      lv = ((drv & wd) | (~drv & ext)) & ~lc;
      foreach (dadr[i])
        rd_chk(0, {8'h00, dadr[i]},
               pbyte(dadr[i], lv) | {7'h0, btn & (i == 0)}, "pin_read");
    end
    lcd <= '0;
    bus(0, 1, 16'h00a2, 8'hfe);
    bus(0, 1, 16'h0091, 8'hff);
    bus(0, 1, 16'h00a1, 8'h02);
    settle(3);
    chk_pin("stored_data", st & DRV, pout & DRV);
    ext <= '0;
    bus(0, 1, 16'h0091, 8'h00);
    bus(0, 1, 16'h00a2, 8'h00);
    for (int c = 0; c < 8; c++) begin
      bus(1, 1, ppc_pkg::CFG_PIN11, {1'b0, 3'(c), 4'h0});
      rd_chk(1, ppc_pkg::CFG_PIN11, {1'b0, 3'(c), 4'h0}, "pin11_sel");
      edge_chk(0, 1, exp_irq(3'(c), 1));
      chk_reg("timer_gate", {6'h0, c == 2, c == 3}, {6'h0, tg0, tg1});
      edge_chk(0, 0, exp_irq(3'(c), 0));
    end
    bus(1, 1, ppc_pkg::CFG_RX, {5'h0, ppc_pkg::RES_HI_RISE});
    rd_chk(1, ppc_pkg::CFG_RX, 8'h04, "rx_sel");
    edge_chk(1, 1, 2'b10);
    for (int m = 0; m < 4; m++) begin
      eck <= 1'($urandom());
      edo <= 1'($urandom());
      edd <= 1'b1;
      bus(1, 1, ppc_pkg::CFG_PULSE_EE, {2'(m), 6'h0});
      settle(3);
      chk_reg("ee_mode", 8'(m), {6'h0, emode});
      chk_pin("ee_oe_b", (m == 1 || m == 2) ? '0 : 30'h30, oe_b & 30'h30);
      if (m == 1 || m == 2)
        chk_pin("ee_pins", {24'h0, edo, eck, 4'h0}, pout & 30'h30);
    end
    bus(1, 1, ppc_pkg::CFG_PULSE_EE, 8'h80);
    edd <= 1'b0;
    ext[5] <= 1'b1;
    settle(5);
    chk_reg("ee_data_in", 8'h01, {7'h0, edi});
    bus(1, 1, ppc_pkg::CFG_PULSE_EE, 8'h00);
    dl = 8'($urandom());
    bus(0, 1, 16'h009e, dl);
    bus(0, 1, 16'h009f, ~dl);
    rd_chk(0, 16'h009e, dl, "ee_data_reg");
    chk_reg("ee_ctrl_out", ~dl, eec);
    chk_reg("ee_data_out", dl, eed);
    for (int k = 0; k < 4; k++) begin
      en = (k == 0) ? 8'h0f : 8'($urandom()) & 8'h0f;
      pls <= 4'($urandom());
      bus(1, 1, ppc_pkg::CFG_PULSE_EE, {4'h0, en[0], en[1], 2'h0});
      bus(1, 1, ppc_pkg::CFG_AUX, {4'h0, en[2], en[3], 2'h0});
      settle(3);
      chk_pin("pulse_oe_b", {20'h0, ~en[3:0], 6'h0}, oe_b & 30'h3c0);
      chk_pin("pulse_out", {20'h0, pls & en[3:0], 6'h0},
              pout & {20'h0, en[3:0], 6'h0});
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
